// File: annunciator_checker_asserts.sv
`timescale 1ns/10ps
module annunciator_checker
	import annunciator_pkg::*;
#(
	parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
	// clock and reset
	input wire logic                ref_clk,
	input wire logic                rst,
	// causes
	input wire logic                emergency_halt_button,
	input wire logic                off_reset_pos,
	input wire logic                gshut_evt,
	input wire logic [N_RELAYS-1:0] relay_energized,
	// effects
	input wire logic                ind_alarm,
	input wire logic                ind_shutdown,
	input wire logic [N_DED-1:0]    ind_dedicated,
	input wire logic                stop_engine,
	input wire logic                start_block,
	input wire logic [2:0]          upper_mode,
	input wire logic [1:0]          upper_phase,
	input wire logic [7:0]          upper_code,
	input wire logic [2:0]          lower_qty,
	input wire logic                lower_service,
	input wire logic                relay_one_mark,
	input wire logic                segments_all_on,
	input wire logic                alarm_mod_lamps,
	input wire logic                alarm_mod_horn
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// alarm lamp run length outside lamp test
	logic [31:0] lit_r;
	always_ff @(posedge ref_clk) begin
		if (rst || !ind_alarm || segments_all_on)
			lit_r <= 32'h0;
		else
			lit_r <= lit_r + 32'h1;
	end

	no_code_a: assert property (
		upper_mode != 3'h1 && upper_mode != 3'h2 |-> upper_code == 8'h00)
		else $error("code shown outside code view");
	halt_stop_a: assert property (
		$rose(emergency_halt_button) |-> ##[1:10] stop_engine && start_block)
		else $error("halt button did not stop engine");
	off_stop_a: assert property ($rose(off_reset_pos) |-> ##[1:10] stop_engine)
		else $error("off position did not stop engine");
	shut_stop_a: assert property (gshut_evt |-> ##2 stop_engine && start_block)
		else $error("shutdown did not stop engine");
	lamp_all_a: assert property (segments_all_on |-> ind_alarm && ind_shutdown &&
		(&ind_dedicated) && alarm_mod_lamps && alarm_mod_horn)
		else $error("lamp test incomplete");
	phase_step_a: assert property ($changed(upper_phase) |-> upper_phase ==
		($past(upper_phase) == 2'h2 ? 2'h0 : $past(upper_phase) + 2'h1))
		else $error("phase skipped");
	qty_step_a: assert property ($changed(lower_qty) |-> lower_qty ==
		($past(lower_qty) == 3'h6 ? 3'h0 : $past(lower_qty) + 3'h1))
		else $error("scroll skipped");
	relay_mark_a: assert property (
		!$past(lower_service) && !$past(segments_all_on) && !$past(rst) && !lower_service
		&& !segments_all_on |-> relay_one_mark == $past(relay_energized[0]))
		else $error("relay mark wrong");
	service_view_a: assert property (
		lower_service && $past(lower_service) |-> upper_mode == 3'h3)
		else $error("service lost upper display");
	blink_span_a: assert property (lit_r <= 32'(BLINK_CYCLES))
		else $error("alarm lamp lit too long");
endmodule // annunciator_checker

bind fault_annunciator_display annunciator_checker #(.BLINK_CYCLES(BLINK_CYCLES)) chk_u (.*);

// File: annunciator_pkg.sv
// Contract
// - eight indicators: alarm, shutdown, six dedicated
// - alarm fault flashes yellow, latches code
// - general shutdown flashes red, stops, shows code
// - dedicated fault flashes own lamp, blocks start
// - dedicated faults carry no fault code
// - oil threshold chosen by idle or rated
// - temperature, speed, level probe raise faults
// - overcrank after total crank time expires
// - emergency halt button stops and blocks start
// - overridden fault: steady lamp, keep running
// - overrides default to shutdown after reset
// - upper display shows phase, key advances
// - lower display scrolls, two seconds each
// - meter key freezes scroll, pointer flashes
// - relay marks shown while relay energized
// - lamp test lights everything, horn on
// - alarm-codes key toggles only while alarm
// - seven keys, service-only keys gated
// - service mode takes over both displays
// - off/reset clears latches, stops engine
package annunciator_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_HZ      = 125_000_000;
	localparam int unsigned SCROLL_S    = 2;
	localparam int unsigned SCROLL_CYC  = SCROLL_S * CLK_HZ;
	localparam int unsigned BLINK_MS    = 500;
	localparam int unsigned BLINK_CYC   = BLINK_MS * (CLK_HZ / 1000);
	localparam int unsigned SEC_CYC     = CLK_HZ;

	// ****************************************
	// sizes
	// ****************************************
	localparam int unsigned N_KEYS   = 7;
	localparam int unsigned N_DED    = 6;
	localparam int unsigned N_PHASES = 3;
	localparam int unsigned N_QTY    = 7;
	localparam int unsigned N_RELAYS = 2;
	localparam int unsigned N_PINS   = 3;

	// ****************************************
	// key, dedicated fault and pin positions
	// ****************************************
	localparam int unsigned KEY_LEFT    = 0;
	localparam int unsigned KEY_PHASE   = 1;
	localparam int unsigned KEY_METER   = 2;
	localparam int unsigned KEY_LAMP    = 3;
	localparam int unsigned KEY_CODES   = 4;
	localparam int unsigned KEY_EXIT    = 5;
	localparam int unsigned KEY_SERVICE = 6;

	localparam int unsigned DED_OIL   = 0;
	localparam int unsigned DED_HALT  = 1;
	localparam int unsigned DED_TEMP  = 2;
	localparam int unsigned DED_SPEED = 3;
	localparam int unsigned DED_LEVEL = 4;
	localparam int unsigned DED_CRANK = 5;

	localparam int unsigned PIN_HALT  = 0;
	localparam int unsigned PIN_LEVEL = 1;
	localparam int unsigned PIN_OFF   = 2;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_OIL_IDLE  = 8'h04;
	localparam logic [7:0] ADDR_OIL_RATED = 8'h08;
	localparam logic [7:0] ADDR_TEMP_LIM  = 8'h0c;
	localparam logic [7:0] ADDR_SPEED_LIM = 8'h10;
	localparam logic [7:0] ADDR_CRANK_LIM = 8'h14;
	localparam logic [7:0] ADDR_STATUS    = 8'h18;
	localparam logic [7:0] ADDR_CODES     = 8'h1c;

	// ctrl fields: override enables
	localparam int unsigned CTRL_OVR_OIL   = 0;
	localparam int unsigned CTRL_OVR_TEMP  = 1;
	localparam int unsigned CTRL_OVR_LEVEL = 2;

	// status field positions
	localparam int unsigned ST_DED     = 0;
	localparam int unsigned ST_ALARM   = 6;
	localparam int unsigned ST_GSHUT   = 7;
	localparam int unsigned ST_STOP    = 8;
	localparam int unsigned ST_BLOCK   = 9;
	localparam int unsigned ST_SERVICE = 10;
	localparam int unsigned ST_FROZEN  = 11;
	localparam int unsigned ST_QTY     = 12;
	localparam int unsigned ST_PHASE   = 16;
	localparam int unsigned ST_ITEM    = 20;

	// reset values
	localparam logic [2:0]  CTRL_RST      = 3'h0;
	localparam logic [15:0] OIL_IDLE_RST  = 16'h0000;
	localparam logic [15:0] OIL_RATED_RST = 16'h0000;
	localparam logic [15:0] TEMP_LIM_RST  = 16'hffff;
	localparam logic [15:0] SPEED_LIM_RST = 16'hffff;
	localparam logic [15:0] CRANK_LIM_RST = 16'h0000;

	typedef enum logic [2:0] {
		UP_GEN,
		UP_ALARM_CODE,
		UP_SHUT_CODE,
		UP_SERVICE,
		UP_LAMP
	} upper_mode_type;

endpackage

// File: fault_annunciator_display.sv
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module fault_annunciator_display
	import annunciator_pkg::*;
#(
	parameter int unsigned SCROLL_CYCLES = SCROLL_CYC,
	parameter int unsigned BLINK_CYCLES  = BLINK_CYC,
	parameter int unsigned SEC_CYCLES    = SEC_CYC
) (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// panel pins
	input  wire logic [N_KEYS-1:0]   key_pin,
	input  wire logic                emergency_halt_button,
	input  wire logic                level_probe_low,
	input  wire logic                off_reset_pos,
	// engine state and measurements
	input  wire logic                engine_running,
	input  wire logic                engine_at_rated,
	input  wire logic                crank_active,
	input  wire logic [15:0]         oil_pressure,
	input  wire logic [15:0]         coolant_temp,
	input  wire logic [15:0]         engine_speed,
	input  wire logic [N_RELAYS-1:0] relay_energized,
	// fault events from the classifier
	input  wire logic                alarm_evt,
	input  wire logic [7:0]          alarm_code,
	input  wire logic                gshut_evt,
	input  wire logic [7:0]          gshut_code,
	// indicators
	output logic                     ind_alarm,
	output logic                     ind_shutdown,
	output logic      [N_DED-1:0]    ind_dedicated,
	// engine control
	output logic                     stop_engine,
	output logic                     start_block,
	// displays
	output logic      [2:0]          upper_mode,
	output logic      [1:0]          upper_phase,
	output logic      [7:0]          upper_code,
	output logic      [2:0]          lower_qty,
	output logic                     lower_pointer,
	output logic                     lower_service,
	output logic                     relay_one_mark,
	output logic                     relay_two_mark,
	output logic                     segments_all_on,
	// optional alarm module
	output logic                     alarm_mod_lamps,
	output logic                     alarm_mod_horn
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	pin_evt_if #(.W(N_KEYS)) key_evt ();
	pin_evt_if #(.W(N_PINS)) pin_evt ();

	pin_sync #(.W(N_KEYS)) u_keys (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pins    (key_pin),
		.evt     (key_evt.src)
	);

	wire [N_PINS-1:0] misc_pins = {off_reset_pos, level_probe_low, emergency_halt_button};

	pin_sync #(.W(N_PINS)) u_pins (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pins    (misc_pins),
		.evt     (pin_evt.src)
	);

	wire off_lvl   = pin_evt.level[PIN_OFF];
	wire halt_lvl  = pin_evt.level[PIN_HALT];
	wire probe_lvl = pin_evt.level[PIN_LEVEL];

	// ****************************************
	// registers
	// ****************************************
	logic [2:0]  ctrl_r;
	logic [15:0] oil_idle_r, oil_rated_r, temp_lim_r, speed_lim_r, crank_lim_r;
	logic [31:0] prdata_r;
	logic        pready_r, pslverr_r;

	// ****************************************
	// apb decode
	// ****************************************
	wire access   = psel & penable;
	wire wr_done  = access & pready_r & pwrite;
	wire sel_ctrl = (paddr == ADDR_CTRL);
	wire sel_oi   = (paddr == ADDR_OIL_IDLE);
	wire sel_or   = (paddr == ADDR_OIL_RATED);
	wire sel_tl   = (paddr == ADDR_TEMP_LIM);
	wire sel_sl   = (paddr == ADDR_SPEED_LIM);
	wire sel_cl   = (paddr == ADDR_CRANK_LIM);
	wire sel_st   = (paddr == ADDR_STATUS);
	wire sel_cd   = (paddr == ADDR_CODES);
	wire mapped   = sel_ctrl | sel_oi | sel_or | sel_tl | sel_sl | sel_cl | sel_st | sel_cd;
	// status is read-only; writing it is an error
	wire bad      = ~mapped | (pwrite & (sel_st | sel_cd));

	// ****************************************
	// fault detection
	// ****************************************
	logic [N_DED-1:0] ded_r;
	logic             alarm_r, gshut_r;
	logic [7:0]       alarm_code_r, gshut_code_r;
	logic [31:0]      sec_cnt_r;
	logic [15:0]      crank_sec_r;

	wire [15:0] oil_lim = engine_at_rated ? oil_rated_r : oil_idle_r;
	wire oil_low   = engine_running & (oil_pressure < oil_lim);
	wire temp_high = coolant_temp > temp_lim_r;
	wire speed_hi  = engine_speed > speed_lim_r;
	wire crank_out = crank_active & ~engine_running & (crank_sec_r >= crank_lim_r);
	wire sec_tick  = (sec_cnt_r == SEC_CYCLES - 1);

	wire [N_DED-1:0] ded_cond = {crank_out, probe_lvl, speed_hi, temp_high, halt_lvl, oil_low};
	// new detections win over a clear in the same cycle
	wire [N_DED-1:0] ded_nxt  = ded_cond | (ded_r & {N_DED{~off_lvl}});

	// overrides only exist for oil, temperature and level
	wire [N_DED-1:0] ovr_mask;
	assign ovr_mask[DED_OIL]   = ctrl_r[CTRL_OVR_OIL];
	assign ovr_mask[DED_HALT]  = 1'b0;
	assign ovr_mask[DED_TEMP]  = ctrl_r[CTRL_OVR_TEMP];
	assign ovr_mask[DED_SPEED] = 1'b0;
	assign ovr_mask[DED_LEVEL] = ctrl_r[CTRL_OVR_LEVEL];
	assign ovr_mask[DED_CRANK] = 1'b0;

	wire [N_DED-1:0] ded_shut   = ded_r & ~ovr_mask;
	wire [N_DED-1:0] ded_steady = ded_r & ovr_mask;

	wire alarm_nxt = alarm_evt | (alarm_r & ~off_lvl);
	wire gshut_nxt = gshut_evt | (gshut_r & ~off_lvl);
	// alarms never touch run state or start permission
	wire block_nxt = (|ded_shut) | gshut_r;
	wire stop_nxt  = block_nxt | off_lvl;

	// ****************************************
	// blink, keys and display state
	// ****************************************
	logic [31:0] blink_cnt_r, scroll_cnt_r;
	logic        blink_r, service_r, frozen_r, alarm_view_r;
	logic [1:0]  phase_r;
	logic [2:0]  qty_r;
	logic [3:0]  item_r;

	wire blink_wrap  = (blink_cnt_r == BLINK_CYCLES - 1);
	wire scroll_wrap = (scroll_cnt_r == SCROLL_CYCLES - 1);
	wire lamp_test   = key_evt.level[KEY_LAMP] & ~service_r;
	// normal-meaning keys are dead in service mode, service keys dead outside
	wire press_phase = key_evt.rise[KEY_PHASE] & ~service_r;
	wire press_meter = key_evt.rise[KEY_METER] & ~service_r;
	wire press_codes = key_evt.rise[KEY_CODES] & ~service_r & alarm_r;
	wire press_left  = key_evt.rise[KEY_LEFT] & service_r;
	wire press_exit  = key_evt.rise[KEY_EXIT] & service_r;
	wire press_serv  = key_evt.rise[KEY_SERVICE];

	wire [1:0] phase_nxt = (phase_r == 2'(N_PHASES - 1)) ? 2'h0 : phase_r + 2'h1;
	wire [2:0] qty_nxt   = (qty_r == 3'(N_QTY - 1)) ? 3'h0 : qty_r + 3'h1;

	upper_mode_type up_sel;
	assign up_sel = lamp_test    ? UP_LAMP :
	                service_r    ? UP_SERVICE :
	                gshut_r      ? UP_SHUT_CODE :
	                alarm_view_r ? UP_ALARM_CODE : UP_GEN;

	// dedicated faults never select a code
	wire [7:0] code_sel = (up_sel == UP_SHUT_CODE) ? gshut_code_r :
	                      (up_sel == UP_ALARM_CODE) ? alarm_code_r : 8'h00;

	wire [N_DED-1:0] ded_lamps = {N_DED{lamp_test}} | (ded_shut & {N_DED{blink_r}}) | ded_steady;

	// ****************************************
	// read mux
	// ****************************************
	wire [31:0] status_word = (32'(ded_r) << ST_DED) | (32'(alarm_r) << ST_ALARM)
		| (32'(gshut_r) << ST_GSHUT) | (32'(stop_engine) << ST_STOP)
		| (32'(start_block) << ST_BLOCK) | (32'(service_r) << ST_SERVICE)
		| (32'(frozen_r) << ST_FROZEN) | (32'(qty_r) << ST_QTY)
		| (32'(phase_r) << ST_PHASE) | (32'(item_r) << ST_ITEM);

	wire [31:0] rd_word = sel_ctrl ? 32'(ctrl_r) :
	                      sel_oi   ? 32'(oil_idle_r) :
	                      sel_or   ? 32'(oil_rated_r) :
	                      sel_tl   ? 32'(temp_lim_r) :
	                      sel_sl   ? 32'(speed_lim_r) :
	                      sel_cl   ? 32'(crank_lim_r) :
	                      sel_st   ? status_word :
	                      sel_cd   ? {16'h0000, gshut_code_r, alarm_code_r} : 32'h0000_0000;

	// ****************************************
	// apb slave: one wait state, registered answer
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= access & ~pready_r;
			pslverr_r <= access & ~pready_r & bad;
			prdata_r  <= (access & ~pready_r & ~pwrite) ? rd_word : 32'h0000_0000;
		end
	end

	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign prdata  = prdata_r;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_r      <= CTRL_RST;
			oil_idle_r  <= OIL_IDLE_RST;
			oil_rated_r <= OIL_RATED_RST;
			temp_lim_r  <= TEMP_LIM_RST;
			speed_lim_r <= SPEED_LIM_RST;
			crank_lim_r <= CRANK_LIM_RST;
		end else if (wr_done) begin
			ctrl_r      <= sel_ctrl ? pwdata[2:0] : ctrl_r;
			oil_idle_r  <= sel_oi ? pwdata[15:0] : oil_idle_r;
			oil_rated_r <= sel_or ? pwdata[15:0] : oil_rated_r;
			temp_lim_r  <= sel_tl ? pwdata[15:0] : temp_lim_r;
			speed_lim_r <= sel_sl ? pwdata[15:0] : speed_lim_r;
			crank_lim_r <= sel_cl ? pwdata[15:0] : crank_lim_r;
		end
	end

	// ****************************************
	// fault latches and crank timer
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ded_r        <= '0;
			alarm_r      <= 1'b0;
			gshut_r      <= 1'b0;
			alarm_code_r <= 8'h00;
			gshut_code_r <= 8'h00;
			sec_cnt_r    <= 32'h0000_0000;
			crank_sec_r  <= 16'h0000;
		end else begin
			ded_r        <= ded_nxt;
			alarm_r      <= alarm_nxt;
			gshut_r      <= gshut_nxt;
			alarm_code_r <= alarm_evt ? alarm_code : alarm_code_r;
			gshut_code_r <= gshut_evt ? gshut_code : gshut_code_r;
			sec_cnt_r    <= (sec_tick | ~crank_active) ? 32'h0000_0000 : sec_cnt_r + 32'h1;
			// total crank time accumulates over rest periods; cleared on start or reset
			if (engine_running | off_lvl)
				crank_sec_r <= 16'h0000;
			else if (sec_tick & (crank_sec_r != 16'hffff))
				crank_sec_r <= crank_sec_r + 16'h1;
		end
	end

	// ****************************************
	// keypad and display state
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			blink_cnt_r  <= 32'h0000_0000;
			blink_r      <= 1'b0;
			scroll_cnt_r <= 32'h0000_0000;
			qty_r        <= 3'h0;
			phase_r      <= 2'h0;
			frozen_r     <= 1'b0;
			alarm_view_r <= 1'b0;
			service_r    <= 1'b0;
			item_r       <= 4'h0;
		end else begin
			blink_cnt_r  <= blink_wrap ? 32'h0000_0000 : blink_cnt_r + 32'h1;
			blink_r      <= blink_wrap ? ~blink_r : blink_r;
			// frozen scroll clears the count so resume restarts a full hold
			scroll_cnt_r <= (frozen_r | scroll_wrap) ? 32'h0000_0000 : scroll_cnt_r + 32'h1;
			qty_r        <= (~frozen_r & scroll_wrap) ? qty_nxt : qty_r;
			phase_r      <= press_phase ? phase_nxt : phase_r;
			frozen_r     <= press_meter ? ~frozen_r : frozen_r;
			alarm_view_r <= alarm_r & (press_codes ? ~alarm_view_r : alarm_view_r);
			service_r    <= press_serv | (service_r & ~press_exit);
			item_r       <= press_left ? item_r + 4'h1 : (service_r ? item_r : 4'h0);
		end
	end

	// ****************************************
	// registered outputs
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ind_alarm       <= 1'b0;
			ind_shutdown    <= 1'b0;
			ind_dedicated   <= '0;
			stop_engine     <= 1'b0;
			start_block     <= 1'b0;
			upper_mode      <= 3'h0;
			upper_phase     <= 2'h0;
			upper_code      <= 8'h00;
			lower_qty       <= 3'h0;
			lower_pointer   <= 1'b0;
			lower_service   <= 1'b0;
			relay_one_mark  <= 1'b0;
			relay_two_mark  <= 1'b0;
			segments_all_on <= 1'b0;
			alarm_mod_lamps <= 1'b0;
			alarm_mod_horn  <= 1'b0;
		end else begin
			ind_alarm       <= lamp_test | (alarm_r & blink_r);
			ind_shutdown    <= lamp_test | (gshut_r & blink_r);
			ind_dedicated   <= ded_lamps;
			stop_engine     <= stop_nxt;
			start_block     <= block_nxt;
			upper_mode      <= up_sel;
			upper_phase     <= phase_r;
			upper_code      <= code_sel;
			lower_qty       <= qty_r;
			lower_pointer   <= lamp_test | (~service_r & (~frozen_r | blink_r));
			lower_service   <= service_r & ~lamp_test;
			relay_one_mark  <= lamp_test | (~service_r & relay_energized[0]);
			relay_two_mark  <= lamp_test | (~service_r & relay_energized[1]);
			segments_all_on <= lamp_test;
			alarm_mod_lamps <= lamp_test;
			alarm_mod_horn  <= lamp_test;
		end
	end

endmodule // fault_annunciator_display

// File: keypad_model.sv
`timescale 1ns/10ps
module keypad_model (
	// clock
	input  wire logic       ref_clk,
	// keys and panel switches, high when pressed
	output logic      [6:0] key_pin,
	output logic      [2:0] panel
);
	initial begin
		key_pin = 7'h00;
		panel   = 3'h0;
	end
	// held past the input filter
	task automatic key(input int k, input logic v);
		@(posedge ref_clk);
		key_pin[k] <= v;
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic tap(input int k);
		key(k, 1'b1);
		key(k, 1'b0);
	endtask
	task automatic sw(input int k, input logic v);
		@(posedge ref_clk);
		panel[k] <= v;
		repeat (8) @(posedge ref_clk);
	endtask
endmodule // keypad_model

// File: pin_evt_if.sv
`timescale 1ns/10ps
interface pin_evt_if #(parameter int unsigned W = 1);
	logic [W-1:0] level;
	logic [W-1:0] rise;
	modport src (output level, output rise);
	modport dst (input level, input rise);
endinterface

// File: pin_sync.sv
`timescale 1ns/10ps
module pin_sync
	import annunciator_pkg::*;
#(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst,
	// raw pins
	input  wire logic [W-1:0] pins,
	// settled levels and press pulses
	pin_evt_if.src            evt
);

	// ****************************************
	// three-stage capture per pin
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_r, s2_r, s3_r, lvl_r, rise_r;
			wire  agree = (s2_r == s3_r);
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					s1_r   <= 1'b0;
					s2_r   <= 1'b0;
					s3_r   <= 1'b0;
					lvl_r  <= 1'b0;
					rise_r <= 1'b0;
				end else begin
					s1_r   <= pins[i];
					s2_r   <= s1_r;
					s3_r   <= s2_r;
					// only a level seen on two stages counts
					lvl_r  <= agree ? s3_r : lvl_r;
					rise_r <= agree & s3_r & ~lvl_r;
				end
			end
			assign evt.level[i] = lvl_r;
			assign evt.rise[i]  = rise_r;
		end
	endgenerate

endmodule // pin_sync

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
	import annunciator_pkg::*;
	logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        engine_running = 1'b0, engine_at_rated = 1'b0, crank_active = 1'b0;
	logic        alarm_evt = 1'b0, gshut_evt = 1'b0, er, pready, pslverr;
	logic [7:0]  paddr = 8'h00, alarm_code = 8'h00, gshut_code = 8'h00, upper_code;
	logic [31:0] pwdata = 32'h0, prdata, rd, lo, hi;
	logic [15:0] oil_pressure = 16'h0, coolant_temp = 16'h0, engine_speed = 16'h0;
	logic [1:0]  relay_energized = 2'h0, upper_phase, marks;
	logic [6:0]  key_pin;
	logic [2:0]  panel, upper_mode, lower_qty;
	logic [5:0]  ind_dedicated;
	logic        ind_alarm, ind_shutdown, stop_engine, start_block, lower_service, seg, ptr;
	int          n_mismatch = 0, compares = 0, exp_phase = 0, n;
	int          codes[$];

	always #4 ref_clk = ~ref_clk;

	keypad_model kb_u (.ref_clk(ref_clk), .key_pin(key_pin), .panel(panel));
	fault_annunciator_display #(.SCROLL_CYCLES(20), .BLINK_CYCLES(4), .SEC_CYCLES(10)) dut_u (
		.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.key_pin(key_pin), .emergency_halt_button(panel[PIN_HALT]),
		.level_probe_low(panel[PIN_LEVEL]), .off_reset_pos(panel[PIN_OFF]),
		.engine_running(engine_running), .engine_at_rated(engine_at_rated),
		.crank_active(crank_active), .oil_pressure(oil_pressure), .coolant_temp(coolant_temp),
		.engine_speed(engine_speed), .relay_energized(relay_energized),
		.alarm_evt(alarm_evt), .alarm_code(alarm_code), .gshut_evt(gshut_evt),
		.gshut_code(gshut_code), .ind_alarm(ind_alarm), .ind_shutdown(ind_shutdown),
		.ind_dedicated(ind_dedicated), .stop_engine(stop_engine), .start_block(start_block),
		.upper_mode(upper_mode), .upper_phase(upper_phase), .upper_code(upper_code),
		.lower_qty(lower_qty), .lower_pointer(ptr), .lower_service(lower_service),
		.relay_one_mark(marks[0]), .relay_two_mark(marks[1]), .segments_all_on(seg),
		.alarm_mod_lamps(), .alarm_mod_horn());

	// ****************************************
	// helpers
	// ****************************************
	task automatic tally_and_finish;
		if (n_mismatch == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		{rd, er} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	// lo: always lit, hi: ever lit
	task automatic look;
		lo = 32'h1ff;
		hi = 32'h0;
		repeat (12) begin
			@(negedge ref_clk);
			lo &= {ptr, ind_alarm, ind_shutdown, ind_dedicated};
			hi |= {ptr, ind_alarm, ind_shutdown, ind_dedicated};
		end
	endtask
	task automatic span;
		rd = 32'(lower_qty);
		n = 0;
		while (32'(lower_qty) === rd && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	task automatic clear;
		@(posedge ref_clk);
		{oil_pressure, coolant_temp, engine_speed} <= {16'h00fa, 32'h0};
		{engine_running, engine_at_rated, crank_active} <= 3'b110;
		kb_u.sw(PIN_HALT, 1'b0);
		kb_u.sw(PIN_LEVEL, 1'b0);
		kb_u.sw(PIN_OFF, 1'b1);
		kb_u.sw(PIN_OFF, 1'b0);
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		tally_and_finish();
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		rd = $urandom(32'h86e3);
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl", rd, 32'h0);
		apb(1'b1, ADDR_STATUS, 32'h1);
		chk("status_write_err", 32'(er), 32'h1);
		kb_u.tap(KEY_CODES);
		chk("codes_key_idle", 32'(upper_mode), 32'h0);
		codes.push_back($urandom % 256);
		codes.push_back($urandom % 256);
		@(posedge ref_clk);
		{alarm_evt, alarm_code} <= {1'b1, 8'(codes[0])};
		@(posedge ref_clk);
		alarm_evt <= 1'b0;
		look();
		chk("alarm_flash", 32'(hi[7] & ~lo[7]), 32'h1);
		chk("alarm_run", 32'({stop_engine, start_block}), 32'h0);
		apb(1'b0, ADDR_CODES, 32'h0);
		chk("alarm_code", rd & 32'hff, 32'(codes[0]));
		kb_u.tap(KEY_CODES);
		chk("code_view", 32'({upper_mode, upper_code}), 32'h100 | 32'(codes[0]));
		kb_u.tap(KEY_CODES);
		chk("gen_view", 32'(upper_mode), 32'h0);
		@(posedge ref_clk);
		{gshut_evt, gshut_code} <= {1'b1, 8'(codes[1])};
		@(posedge ref_clk);
		gshut_evt <= 1'b0;
		look();
		chk("shut_flash", 32'(hi[6] & ~lo[6]), 32'h1);
		chk("shut_view", 32'({upper_mode, upper_code}), 32'h200 | 32'(codes[1]));
		clear();
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("off_clear", rd & 32'h3ff, 32'h0);
		for (int i = 0; i < 4; i++) begin
			kb_u.tap(KEY_PHASE);
			exp_phase = (exp_phase + 1) % 3;
			chk("phase", 32'(upper_phase), 32'(exp_phase));
		end
		span();
		span();
		chk("scroll_span", n, 20);
		kb_u.tap(KEY_METER);
		look();
		chk("ptr_flash", 32'(hi[8] & ~lo[8]), 32'h1);
		span();
		chk("frozen", n, 100);
		kb_u.tap(KEY_METER);
		span();
		span();
		chk("resumed", n, 20);
		apb(1'b1, ADDR_OIL_IDLE, 32'h64);
		apb(1'b1, ADDR_OIL_RATED, 32'hc8);
		apb(1'b1, ADDR_TEMP_LIM, 32'h12c);
		apb(1'b1, ADDR_SPEED_LIM, 32'h190);
		apb(1'b1, ADDR_CRANK_LIM, 32'h1);
		for (int b = 0; b < 6; b++) begin
			{engine_running, engine_at_rated, oil_pressure} <= {2'b10, 16'h0096};
			repeat (8) @(posedge ref_clk);
			chk("oil_idle_ok", 32'(ind_dedicated), 32'h0);
			{engine_at_rated, oil_pressure} <= {1'b1, b ? 16'h00fa : 16'h0096};
			case (b)
				0: ;
				1: kb_u.sw(PIN_HALT, 1'b1);
				2: coolant_temp <= 16'h012d;
				3: engine_speed <= 16'h0191;
				4: kb_u.sw(PIN_LEVEL, 1'b1);
				default: {engine_running, crank_active} <= 2'b01;
			endcase
			repeat (20) @(posedge ref_clk);
			look();
			chk("ded_flash", 32'(hi & ~lo), 32'(1 << b));
			chk("ded_stop", 32'({stop_engine, start_block, upper_mode}), 32'h18);
			clear();
			chk("ded_clear", 32'(ind_dedicated), 32'h0);
		end
		apb(1'b1, ADDR_CTRL, 32'h7);
		{oil_pressure, coolant_temp} <= {16'h0096, 16'h012d};
		kb_u.sw(PIN_LEVEL, 1'b1);
		look();
		chk("ovr_steady", 32'(lo & 8'h15), 32'h15);
		chk("ovr_run", 32'(stop_engine), 32'h0);
		clear();
		apb(1'b1, ADDR_CTRL, 32'h0);
		kb_u.key(KEY_LAMP, 1'b1);
		chk("lamp", 32'({seg, upper_mode}), 32'hc);
		kb_u.key(KEY_LAMP, 1'b0);
		kb_u.tap(KEY_LEFT);
		kb_u.tap(KEY_SERVICE);
		kb_u.tap(KEY_LEFT);
		kb_u.tap(KEY_PHASE);
		chk("service", 32'({lower_service, upper_mode, upper_phase}), 32'h2c | exp_phase);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("item", rd >> ST_ITEM & 32'hf, 32'h1);
		kb_u.tap(KEY_EXIT);
		chk("exit", 32'({lower_service, upper_mode}), 32'h0);
		repeat (8) begin
			@(posedge ref_clk);
			relay_energized <= 2'($urandom);
			repeat (3) @(posedge ref_clk);
			chk("relay_marks", 32'(marks), 32'(relay_energized));
		end
		tally_and_finish();
	end
endmodule // testbench
